// >>> core/ptd_pkg.sv
// shared constants and types of the pci target image decoder
`default_nettype none
package ptd_pkg;
  // -------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_CTL0  = 8'h00;
  localparam logic [7:0] OFS_ADDR0 = 8'h04;
  localparam logic [7:0] OFS_CFGB0 = 8'h08;
  localparam logic [7:0] OFS_CTL1  = 8'h0c;
  localparam logic [7:0] OFS_ADDR1 = 8'h10;
  localparam logic [7:0] OFS_CFGB1 = 8'h14;
  localparam logic [7:0] OFS_MISC  = 8'h18;
  localparam logic [7:0] OFS_MISC2 = 8'h1c;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int CTL_EN = 31;
  localparam int CTL_SS = 30;
  localparam int CTL_PW = 29;
  localparam int CTL_PF = 28;
  localparam int CTL_BW = 27;
  localparam int CTL_FL = 26;
  localparam int CTL_WD = 24;
  localparam int CTL_BS = 20;
  localparam int CTL_TC = 16;
  localparam int ADR_TA = 16;
  localparam int MSC_BO = 8;
  localparam int M2_PIP = 8;
  localparam int M2_B4  = 9;
  localparam int M2_SB  = 10;
  localparam int M2_HB  = 11;
  localparam int M2_HLD = 12;
  localparam int EE0_BIT = 5;
  localparam int EE1_BIT = 7;
  // -------------------------------------------------------------
  // reset values and codes
  // -------------------------------------------------------------
  localparam logic [15:0] RST_BASE = 16'h0000;
  localparam logic [3:0]  RST_BS   = 4'h0;
  localparam logic [5:0]  RST_PFD  = 6'h00;
  localparam logic [1:0]  PW_32 = 2'h0;
  localparam logic [1:0]  PW_16 = 2'h1;
  localparam logic [1:0]  PW_8  = 2'h2;
  localparam logic [1:0]  CL_NONE = 2'h0;
  localparam logic [1:0]  CL_MEM  = 2'h1;
  localparam logic [1:0]  CL_IO   = 2'h2;
  localparam logic [1:0]  CL_CFG  = 2'h3;
  localparam int DEVSEL_CLKS = 2;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_DECODE = 3'h2,
    ST_CLAIM  = 3'h4
  } ptd_st_t;
  typedef struct packed {
    logic        en;
    logic        ss;
    logic        post;
    logic        pf;
    logic        bw;
    logic        flip;
    logic [1:0]  width;
    logic [3:0]  bs;
    logic [3:0]  tc;
    logic [15:0] base;
    logic [15:0] ta;
    logic        ee;
  } ptd_img_t;
  typedef struct packed {
    logic [7:0] byte7;
    logic [7:0] byte8;
    logic [3:0] bs0;
    logic       ss0;
    logic [3:0] bs1;
    logic       ss1;
  } ptd_ee_t;
  typedef struct packed {
    logic       img;
    logic       wr;
    logic       io;
    logic [3:0] tc;
    logic [1:0] width;
    logic       little;
    logic       post;
    logic       prefetch;
    logic       burst_rd;
    logic       burst_wr;
    logic       beats4;
    logic       single_pf;
    logic       hold_bb;
    logic [5:0] pf_depth;
  } ptd_req_t;
endpackage
`default_nettype wire

// >>> core/ptd_decoder.sv
// two-image pci target address decoder with register file
// Operation
// - two images, each enabled; none enabled claims no memory or io cycle
// - space bit picks memory or io commands
// - block code sets compared upper address bits
// - local address swaps decoded bits for translation
// - devsel within two clocks of frame
// - accepted commands, read/write aliases folded
// - drive image cycle code on local cycles
// - per-image posted or delayed writes
// - prefetch enable, depth global or image one
// - burst write enable, four-beat global choice
// - single-beat prefetch in burst mode
// - hold bus busy across back-to-back cycles
// - per-image flip of global byte order
// - per-image local port width
// - eeprom bits enable image base setup
// - eeprom loads size and space read-only
// - eeprom mode: base written via config register
// - config base writable only above block size
// - otherwise base via address register, no sizing
// - hold bit retries all claimed pci accesses, memory, io and config alike
// - port width 32, 16 or 8 bits
// - bursts only in burst-capable master mode
`default_nettype none
module ptd_decoder
  import ptd_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        FRAME_N_I,
  input  wire logic [31:0] AD_I,
  input  wire logic [3:0]  CBE_N_I,
  input  wire logic        IDSEL_I,
  input  wire logic        HOLD_STRAP_I,
  input  wire logic        BURST_MODE_I,
  input  wire logic        EE_LOAD_I,
  input  wire ptd_ee_t     EE_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [31:0]      REG_RDATA_O,
  output logic             DEVSEL_N_O,
  output logic             DEVSEL_OE_O,
  output logic             STOP_N_O,
  output logic             STOP_OE_O,
  output logic             CFG_HIT_O,
  output logic             LB_START_O,
  output logic [31:0]      LB_ADDR_O,
  output ptd_req_t         LB_REQ_O
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    ptd_st_t         st;
    ptd_img_t [1:0]  img;
    logic [5:0]      pfd;
    logic [5:0]      pfd2;
    logic            little;
    logic            per_img;
    logic            beats4;
    logic            single_pf;
    logic            hold_bb;
    logic            hold;
    logic            burst_mode;
    logic            strap_done;
    logic            frame_q;
    logic [31:0]     ad;
    logic [3:0]      cmd;
    logic            idsel;
    logic            devsel_n;
    logic            stop_n;
    logic            oe;
    logic            start;
    logic            cfg_hit;
    logic [31:0]     laddr;
    ptd_req_t        req;
    logic [31:0]     rdata;
  } ptd_core_t;

  ptd_core_t q;
  ptd_core_t n;
  logic      rst_meta_r;
  logic      rst_sync_r;
  logic [2:0] cls;
  logic [1:0] hit;
  logic       cfg_ok;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] size_mask(input logic [3:0] bs);
    size_mask = 16'hffff << bs;
  endfunction

  // returns {class, write}
  function automatic logic [2:0] cmd_decode(input logic [3:0] c);
    case (c)
      4'h2:    cmd_decode = {CL_IO, 1'b0};
      4'h3:    cmd_decode = {CL_IO, 1'b1};
      4'h6,
      4'hc,
      4'he:    cmd_decode = {CL_MEM, 1'b0};
      4'h7,
      4'hf:    cmd_decode = {CL_MEM, 1'b1};
      4'ha:    cmd_decode = {CL_CFG, 1'b0};
      4'hb:    cmd_decode = {CL_CFG, 1'b1};
      default: cmd_decode = {CL_NONE, 1'b0};
    endcase
  endfunction

  function automatic logic img_hit(input ptd_img_t m, input logic [1:0] c,
                                   input logic [15:0] a);
    img_hit = m.en
      && ((m.ss && c == CL_IO) || (!m.ss && c == CL_MEM))
      && (((a ^ m.base) & size_mask(m.bs)) == 16'h0000);
  endfunction

  function automatic logic [31:0] ctl_rd(input ptd_img_t m);
    ctl_rd = {m.en, m.ss, m.post, m.pf, m.bw, m.flip, m.width,
              m.bs, m.tc, 16'h0000};
  endfunction

  assign cls    = cmd_decode(q.cmd);
  assign hit[0] = img_hit(q.img[0], cls[2:1], q.ad[31:16]);
  assign hit[1] = img_hit(q.img[1], cls[2:1], q.ad[31:16]);
  assign cfg_ok = cls[2:1] == CL_CFG && q.idsel && q.ad[1:0] == 2'h0;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    logic       sel;
    logic [15:0] mk;
    logic [7:0] oc;
    logic [7:0] oa;
    logic [7:0] ob;
    sel = 1'b0;
    mk  = 16'h0000;
    oc  = 8'h00;
    oa  = 8'h00;
    ob  = 8'h00;
    n = q;
    n.frame_q = FRAME_N_I;
    n.start   = 1'b0;
    n.cfg_hit = 1'b0;
    // eeprom setup load
    if (EE_LOAD_I) begin
      n.img[0].ee = EE_I.byte7[EE0_BIT];
      n.img[1].ee = EE_I.byte8[EE1_BIT];
      if (EE_I.byte7[EE0_BIT]) begin
        n.img[0].bs = EE_I.bs0;
        n.img[0].ss = EE_I.ss0;
      end
      if (EE_I.byte8[EE1_BIT]) begin
        n.img[1].bs = EE_I.bs1;
        n.img[1].ss = EE_I.ss1;
      end
    end
    // register writes; port only used while device is not mastering
    for (int i = 0; i < 2; i++) begin
      oc = (i == 1) ? OFS_CTL1 : OFS_CTL0;
      oa = (i == 1) ? OFS_ADDR1 : OFS_ADDR0;
      ob = (i == 1) ? OFS_CFGB1 : OFS_CFGB0;
      mk = size_mask(q.img[i].bs);
      if (REG_WR_I && REG_ADDR_I == oc) begin
        n.img[i].en    = REG_WDATA_I[CTL_EN];
        n.img[i].post  = REG_WDATA_I[CTL_PW];
        n.img[i].pf    = REG_WDATA_I[CTL_PF];
        n.img[i].bw    = REG_WDATA_I[CTL_BW];
        n.img[i].flip  = REG_WDATA_I[CTL_FL];
        n.img[i].width = REG_WDATA_I[CTL_WD +: 2];
        n.img[i].tc    = REG_WDATA_I[CTL_TC +: 4];
        if (!q.img[i].ee) begin
          n.img[i].ss = REG_WDATA_I[CTL_SS];
          n.img[i].bs = REG_WDATA_I[CTL_BS +: 4];
        end
      end
      if (REG_WR_I && REG_ADDR_I == oa) begin
        n.img[i].ta = REG_WDATA_I[ADR_TA +: 16];
        if (!q.img[i].ee) begin
          n.img[i].base = REG_WDATA_I[15:0];
        end
      end
      if (REG_WR_I && REG_ADDR_I == ob && q.img[i].ee) begin
        n.img[i].base = REG_WDATA_I[31:16] & mk;
      end
    end
    if (REG_WR_I && REG_ADDR_I == OFS_MISC) begin
      n.pfd    = REG_WDATA_I[5:0];
      n.little = REG_WDATA_I[MSC_BO];
    end
    if (REG_WR_I && REG_ADDR_I == OFS_MISC2) begin
      n.pfd2      = REG_WDATA_I[5:0];
      n.per_img   = REG_WDATA_I[M2_PIP];
      n.beats4    = REG_WDATA_I[M2_B4];
      n.single_pf = REG_WDATA_I[M2_SB];
      n.hold_bb   = REG_WDATA_I[M2_HB];
      n.hold      = REG_WDATA_I[M2_HLD];
    end
    // straps caught once after reset release, winning over a write
    if (!q.strap_done) begin
      n.strap_done = 1'b1;
      n.hold       = HOLD_STRAP_I;
      n.burst_mode = BURST_MODE_I;
    end
    // register reads, answer stands one cycle
    n.rdata = 32'h0000_0000;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        OFS_CTL0:  n.rdata = ctl_rd(q.img[0]);
        OFS_CTL1:  n.rdata = ctl_rd(q.img[1]);
        OFS_ADDR0: n.rdata = {q.img[0].ta, q.img[0].base};
        OFS_ADDR1: n.rdata = {q.img[1].ta, q.img[1].base};
        OFS_CFGB0: n.rdata = {q.img[0].base, 15'h0000, q.img[0].ss};
        OFS_CFGB1: n.rdata = {q.img[1].base, 15'h0000, q.img[1].ss};
        OFS_MISC:  n.rdata = {23'h000000, q.little, 2'h0, q.pfd};
        OFS_MISC2: n.rdata = {19'h00000, q.hold, q.hold_bb, q.single_pf,
                              q.beats4, q.per_img, 2'h0, q.pfd2};
        default:   n.rdata = 32'h0000_0000;
      endcase
    end
    // address phase sequencing
    case (q.st)
      ST_IDLE: begin
        if (!FRAME_N_I && q.frame_q) begin
          n.ad    = AD_I;
          n.cmd   = ~CBE_N_I;
          n.idsel = IDSEL_I;
          n.st    = ST_DECODE;
        end
      end
      ST_DECODE: begin
        n.st = ST_IDLE;
        if (hit != 2'h0 || cfg_ok) begin
          n.devsel_n = 1'b0;
          n.oe       = 1'b1;
          n.stop_n   = !q.hold;
          n.st       = ST_CLAIM;
          n.cfg_hit  = cfg_ok && !q.hold;
          if (hit != 2'h0 && !q.hold) begin
            sel = !hit[0];
            mk  = size_mask(q.img[sel].bs);
            n.start = 1'b1;
            n.laddr = {(q.img[sel].ta & mk) | (q.ad[31:16] & ~mk),
                       q.ad[15:0]};
            n.req.img      = sel;
            n.req.wr       = cls[0];
            n.req.io       = q.img[sel].ss;
            n.req.tc       = q.img[sel].tc;
            n.req.width    = q.img[sel].width;
            n.req.little   = q.little ^ q.img[sel].flip;
            n.req.post     = cls[0] && q.img[sel].post;
            n.req.prefetch = !cls[0] && q.img[sel].pf;
            n.req.pf_depth = (sel && q.per_img) ? q.pfd2 : q.pfd;
            n.req.burst_rd = !cls[0] && q.img[sel].pf && q.burst_mode
                             && !q.single_pf;
            n.req.burst_wr = cls[0] && q.img[sel].bw && q.burst_mode;
            n.req.beats4   = q.beats4;
            n.req.single_pf = q.single_pf && q.burst_mode;
            n.req.hold_bb  = q.hold_bb;
          end
        end
      end
      ST_CLAIM: begin
        if (FRAME_N_I) begin
          n.devsel_n = 1'b1;
          n.stop_n   = 1'b1;
          n.oe       = 1'b0;
          n.st       = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.frame_q  <= 1'b1;
      q.devsel_n <= 1'b1;
      q.stop_n   <= 1'b1;
      q.pfd      <= RST_PFD;
      q.pfd2     <= RST_PFD;
      for (int i = 0; i < 2; i++) begin
        q.img[i].base  <= RST_BASE;
        q.img[i].bs    <= RST_BS;
        q.img[i].width <= PW_32;
      end
    end else begin
      q <= n;
    end
  end

  assign REG_RDATA_O = q.rdata;
  assign DEVSEL_N_O  = q.devsel_n;
  assign DEVSEL_OE_O = q.oe;
  assign STOP_N_O    = q.stop_n;
  assign STOP_OE_O   = q.oe;
  assign CFG_HIT_O   = q.cfg_hit;
  assign LB_START_O  = q.start;
  assign LB_ADDR_O   = q.laddr;
  assign LB_REQ_O    = q.req;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!rst_sync_r);

  chk_devsel_latency: assert property (
    (q.st == ST_IDLE && !FRAME_N_I && q.frame_q) ##1 (hit != 2'h0)
      |=> !DEVSEL_N_O && DEVSEL_OE_O)
    else $error("devsel late");
  chk_none_enabled: assert property (
    (q.st == ST_DECODE && !q.img[0].en && !q.img[1].en && !cfg_ok)
      |=> DEVSEL_N_O && !LB_START_O)
    else $error("claim with no image enabled");
  chk_hold_retry: assert property (
    (q.st == ST_DECODE && (hit != 2'h0 || cfg_ok) && q.hold)
      |=> !STOP_N_O && !LB_START_O && !CFG_HIT_O)
    else $error("no retry under hold");
  chk_cycle_code: assert property (
    LB_START_O |-> LB_REQ_O.tc == q.img[LB_REQ_O.img].tc)
    else $error("wrong cycle code");
  chk_low_bits: assert property (
    LB_START_O |-> LB_ADDR_O[15:0] == q.ad[15:0]
      && ((LB_ADDR_O[31:16] ^ q.img[LB_REQ_O.img].ta)
          & size_mask(q.img[LB_REQ_O.img].bs)) == 16'h0000)
    else $error("bad translation");
  chk_space_match: assert property (
    LB_START_O |-> LB_REQ_O.io == (cls[2:1] == CL_IO))
    else $error("space mismatch");
  chk_image_prio: assert property (
    (q.st == ST_DECODE && hit == 2'h3 && !q.hold) |=> LB_REQ_O.img == 1'b0)
    else $error("image 1 won");
  chk_ee_readonly: assert property (
    (REG_WR_I && REG_ADDR_I == OFS_CTL0 && q.img[0].ee && !EE_LOAD_I)
      |=> q.img[0].bs == $past(q.img[0].bs))
    else $error("eeprom size overwritten");
  chk_base_sizing: assert property (
    (REG_WR_I && REG_ADDR_I == OFS_CFGB0 && q.img[0].ee)
      |=> (q.img[0].base & ~size_mask(q.img[0].bs)) == 16'h0000)
    else $error("base bits below size kept");
  chk_burst_mode: assert property (
    (LB_START_O && !q.burst_mode) |-> !LB_REQ_O.burst_rd && !LB_REQ_O.burst_wr)
    else $error("burst outside burst mode");

  cov_claim_img0: cover property (LB_START_O && LB_REQ_O.img == 1'b0);
  cov_claim_img1: cover property (LB_START_O && LB_REQ_O.img == 1'b1);
  cov_retry:      cover property (!STOP_N_O && !DEVSEL_N_O);
  cov_config:     cover property (CFG_HIT_O);
endmodule
`default_nettype wire

// >>> tb/ptd_pci_master.sv
// pci master model driving address phases into the decoder
`default_nettype none
module ptd_pci_master (
  input  wire logic        clk_i,
  output logic             frame_n_o,
  output logic [31:0]      ad_o,
  output logic [3:0]       cbe_n_o,
  output logic             idsel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  initial begin
    frame_n_o = 1'b1;
    ad_o      = 32'h0;
    cbe_n_o   = 4'hf;
    idsel_o   = 1'b0;
  end
  // released lines toggle so a stale address never decodes
  always @(posedge clk_i) begin
    if (!busy) begin
      ad_o    <= ~ad_o;
      cbe_n_o <= ~cbe_n_o;
    end
  end
  // one transaction: address phase, then len data clocks
  task automatic frame(input logic [31:0] a, input logic [3:0] c, input logic s, input int len);
    busy = 1'b1;
    @(posedge clk_i);
    frame_n_o <= 1'b0;
    ad_o      <= a;
    cbe_n_o   <= ~c;
    idsel_o   <= s;
    @(posedge clk_i);
    ad_o    <= ~a;
    cbe_n_o <= 4'h0;
    idsel_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    frame_n_o <= 1'b1;
    @(posedge clk_i);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/ptd_decoder_tb.sv
// self-checking bench of the two-image target decoder
`default_nettype none
module ptd_decoder_tb
  import ptd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ee_load = 1'b0;
  ptd_ee_t     ee = '0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, lb_addr, cap_addr;
  logic        devsel_n, devsel_oe, stop_n, cfg_hit, lb_start;
  ptd_req_t    lb_req, cap_req;
  logic        frame_n, idsel;
  logic [31:0] ad;
  logic [3:0]  cbe_n;
  logic        spf = 1'b0;
  logic        hold_strap  = 1'b1;
  logic        burst_strap = 1'b1;
  logic        stop_oe;
  ptd_req_t    rq;
  logic [3:0]  tc1 = 4'h3;
  logic [1:0]  pw1 = PW_8;
  logic        le1 = 1'b0;
  logic [3:0]  cmds [5] = '{4'h6, 4'hc, 4'he, 4'h7, 4'hf};
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;
  int          fe, de, starts, cfgs, stops, oes;

  always #5 clk = ~clk;

  ptd_decoder dut_u (
    .REF_CLK_I    (clk),
    .RST_N_I      (rst_n),
    .FRAME_N_I    (frame_n),
    .AD_I         (ad),
    .CBE_N_I      (cbe_n),
    .IDSEL_I      (idsel),
    .HOLD_STRAP_I (hold_strap),
    .BURST_MODE_I (burst_strap),
    .EE_LOAD_I    (ee_load),
    .EE_I         (ee),
    .REG_ADDR_I   (reg_addr),
    .REG_WDATA_I  (reg_wdata),
    .REG_WR_I     (reg_wr),
    .REG_RD_I     (reg_rd),
    .REG_RDATA_O  (reg_rdata),
    .DEVSEL_N_O   (devsel_n),
    .DEVSEL_OE_O  (devsel_oe),
    .STOP_N_O     (stop_n),
    .STOP_OE_O    (stop_oe),
    .CFG_HIT_O    (cfg_hit),
    .LB_START_O   (lb_start),
    .LB_ADDR_O    (lb_addr),
    .LB_REQ_O     (lb_req)
  );

  ptd_pci_master pm_u (
    .clk_i     (clk),
    .frame_n_o (frame_n),
    .ad_o      (ad),
    .cbe_n_o   (cbe_n),
    .idsel_o   (idsel)
  );

  // edge monitor of claim, start and retry outputs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!frame_n && fe < 0) fe = cyc;
    if (!devsel_n && de < 0 && fe >= 0) de = cyc;
    if (lb_start) begin
      starts++;
      cap_addr = lb_addr;
      cap_req = lb_req;
    end
    if (cfg_hit) cfgs++;
    if (!stop_n) stops++;
    if (stop_oe) oes++;
    if (cyc == 4000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // register port used only between frames, never during a local cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(n, reg_rdata, e);
  endtask

  function automatic ptd_req_t mk_req(input logic i, input logic w, input logic io);
    ptd_req_t r;
    r           = '0;
    r.img       = i;
    r.wr        = w;
    r.io        = io;
    r.tc        = i ? tc1 : 4'h9;
    r.width     = i ? pw1 : PW_16;
    r.little    = i ? le1 : 1'b1;
    r.post      = w & ~i;
    r.prefetch  = ~w & ~i;
    r.burst_rd  = ~w & ~i & ~spf;
    r.burst_wr  = w & ~i;
    r.beats4    = 1'b1;
    r.single_pf = spf;
    r.hold_bb   = 1'b1;
    r.pf_depth  = i ? 6'h2a : 6'h15;
    return r;
  endfunction

  // k: 0 ignored, 1 local cycle, 2 config claim, 3 retried
  task automatic run(input logic [31:0] a, input logic [3:0] c, input logic s, input int k,
                     input logic [31:0] ea, input ptd_req_t er);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    fe     = -1;
    de     = -1;
    starts = 0;
    cfgs   = 0;
    stops  = 0;
    oes    = 0;
    pm_u.frame(a, c, s, 2);
    repeat (3) @(posedge clk);
    chk("claim", 32'(de >= 0), 32'(k != 0));
    if (k != 0) chk("devsel_clks", 32'(de - fe), 32'(DEVSEL_CLKS));
    chk("lb_starts", 32'(starts), 32'(k == 1));
    chk("cfg_hits", 32'(cfgs), 32'(k == 2));
    chk("retry", 32'(stops > 0), 32'(k == 3));
    chk("released", 32'(devsel_oe), 32'h0);
    chk("stop_oe_clks", 32'(oes), (k != 0) ? 32'h2 : 32'h0);
    if (k == 1) begin
      chk("lb_addr", cap_addr, ea);
      chk("lb_req", 32'(cap_req), 32'(er));
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(OFS_CTL0, 32'h0, "ctl0_rst");
    rd_chk(OFS_MISC2, 32'h0000_1000, "misc2_rst");
    rd_chk(8'h40, 32'h0, "unmapped");
    ee      <= '{8'h20, 8'h7f, 4'hb, 1'b0, 4'h7, 1'b1};
    ee_load <= 1'b1;
    @(posedge clk);
    ee_load <= 1'b0;
    rd_chk(OFS_CTL0, 32'h00b0_0000, "ctl0_ee");
    rd_chk(OFS_CTL1, 32'h0, "ctl1_no_ee");
    wr_reg(OFS_CTL0, 32'hf909_0000);
    rd_chk(OFS_CTL0, 32'hb9b9_0000, "ctl0_ro");
    wr_reg(OFS_CFGB0, 32'hffff_ffff);
    rd_chk(OFS_CFGB0, 32'hf800_0000, "cfgb0_size");
    rd_chk(OFS_ADDR0, 32'h0000_f800, "addr0_base");
    wr_reg(OFS_CFGB0, 32'h3000_0000);
    wr_reg(OFS_ADDR0, 32'h5800_1234);
    rd_chk(OFS_ADDR0, 32'h5800_3000, "addr0_ro");
    wr_reg(OFS_CTL1, 32'hc633_0000);
    wr_reg(OFS_ADDR1, 32'habcd_ffff);
    wr_reg(OFS_CFGB1, 32'h0);
    rd_chk(OFS_CFGB1, 32'hffff_0001, "cfgb1_ro");
    rd_chk(OFS_ADDR1, 32'habcd_ffff, "addr1_nosize");
    rd_chk(OFS_CTL1, 32'hc633_0000, "ctl1_rw");
    wr_reg(OFS_ADDR1, 32'habcd_1238);
    wr_reg(OFS_MISC, 32'h0000_0115);
    wr_reg(OFS_MISC2, 32'h0000_1b2a);
    run(32'h3123_4568, 4'h6, 1'b0, 3, 32'h0, '0);
    wr_reg(OFS_MISC2, 32'h0000_0b2a);
    rd_chk(OFS_MISC2, 32'h0000_0b2a, "hold_clr");
    for (int i = 0; i < 5; i++) begin
      run(32'h3123_4568, cmds[i], 1'b0, 1, 32'h5923_4568, mk_req(1'b0, i > 2, 1'b0));
    end
    run(32'h37ff_fffc, 4'h7, 1'b0, 1, 32'h5fff_fffc, mk_req(1'b0, 1'b1, 1'b0));
    run(32'h3800_0000, 4'h6, 1'b0, 0, 32'h0, '0);
    run(32'h1238_0010, 4'h2, 1'b0, 1, 32'habc8_0010, mk_req(1'b1, 1'b0, 1'b1));
    run(32'h123f_fffc, 4'h3, 1'b0, 1, 32'habcf_fffc, mk_req(1'b1, 1'b1, 1'b1));
    run(32'h1238_0010, 4'h6, 1'b0, 0, 32'h0, '0);
    run(32'h3000_0000, 4'h3, 1'b0, 0, 32'h0, '0);
    run(32'h3123_4568, 4'h0, 1'b0, 0, 32'h0, '0);
    run(32'h0000_0010, 4'ha, 1'b1, 2, 32'h0, '0);
    run(32'h0000_0011, 4'hb, 1'b1, 0, 32'h0, '0);
    wr_reg(OFS_MISC2, 32'h0000_0f2a);
    spf = 1'b1;
    run(32'h3123_4568, 4'h6, 1'b0, 1, 32'h5923_4568, mk_req(1'b0, 1'b0, 1'b0));
    wr_reg(OFS_CTL1, 32'h80f0_0000);
    wr_reg(OFS_ADDR1, 32'h0000_8000);
    tc1 = 4'h0;
    pw1 = PW_32;
    le1 = 1'b1;
    run(32'h9234_5678, 4'h7, 1'b0, 1, 32'h1234_5678, mk_req(1'b1, 1'b1, 1'b0));
    wr_reg(OFS_ADDR1, 32'h0000_0000);
    run(32'h37ff_fffc, 4'h7, 1'b0, 1, 32'h5fff_fffc, mk_req(1'b0, 1'b1, 1'b0));
    wr_reg(OFS_CTL0, 32'h0);
    wr_reg(OFS_CTL1, 32'h0);
    run(32'h3123_4568, 4'h6, 1'b0, 0, 32'h0, '0);
    // second reset with both straps low: no hold, single-cycle master mode
    rst_n       <= 1'b0;
    hold_strap  <= 1'b0;
    burst_strap <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(OFS_MISC2, 32'h0, "misc2_rst2");
    rd_chk(OFS_ADDR0, 32'h0, "addr0_rst2");
    wr_reg(OFS_CTL0, 32'hb800_0000);
    wr_reg(OFS_ADDR0, 32'h4000_3000);
    rd_chk(OFS_CTL0, 32'hb800_0000, "ctl0_rw2");
    rd_chk(OFS_ADDR0, 32'h4000_3000, "addr0_rw2");
    rq          = '0;
    rq.prefetch = 1'b1;
    run(32'h3000_0040, 4'h6, 1'b0, 1, 32'h4000_0040, rq);
    rq      = '0;
    rq.wr   = 1'b1;
    rq.post = 1'b1;
    run(32'h3000_0044, 4'h7, 1'b0, 1, 32'h4000_0044, rq);
    print_verdict();
  end
endmodule
`default_nettype wire
